// >>> design/asc_consts.svh
// Constants of the monitoring converter scan control block
// Assumes inclusion by bare name from design files only
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ==========================================================
// Register offsets
`define ASC_OFS_RESULT_HI 8'h07
`define ASC_OFS_RESULT_LO 8'h08
`define ASC_OFS_CONV_CFG 8'h09
`define ASC_OFS_CHAN_SEL 8'h0a
`define ASC_OFS_LDO_CTRL 8'h0b

// ==========================================================
// Conversion config field positions
`define ASC_CFG_ENABLE 7
`define ASC_CFG_ONE_SHOT 6
`define ASC_CFG_ALL_SCAN 5
`define ASC_CFG_BUF_DIS 4
`define ASC_CFG_SWAP 3

// ==========================================================
// Channel select field positions
`define ASC_SEL_READY 7
`define ASC_SEL_RB_HI 5
`define ASC_SEL_RB_LO 3
`define ASC_SEL_CV_HI 2
`define ASC_SEL_CV_LO 0

// ==========================================================
// LDO control field positions
`define ASC_LDO_MANUAL 1
`define ASC_LDO_SOURCE 0
`define ASC_LDO_RFU_HI 7
`define ASC_LDO_RFU_LO 2

// ==========================================================
// Reset values
`define ASC_RST_CONV_CFG 5'h0_0
`define ASC_RST_CHAN_SEL 6'h0_0
`define ASC_RST_LDO_RFU 6'h2_0
`define ASC_RST_LDO_CTRL 2'h0

// ==========================================================
// Channel number bounds
`define ASC_LAST_CHAN 3'h7
`define ASC_FIRST_CHAN 3'h0

`endif

// >>> design/asc_pkg.sv
// Types of the monitoring converter scan control block
// Assumes nothing beyond a SystemVerilog compiler
package asc_pkg;

  // ==========================================================
  // Sequencer states, Gray coded along idle, start, wait, halt
  typedef enum logic [1:0] {
    ASC_IDLE = 2'h0,
    ASC_START = 2'h1,
    ASC_WAIT = 2'h3,
    ASC_HALT = 2'h2
  } asc_state_type;

endpackage : asc_pkg

// >>> design/asc_scan_control.sv
// Scan sequencer and register file of the monitoring converter
// Assumes a serial bus engine giving byte register accesses and an analog converter with start and done
// Overview of operation
// - Enable set, one-shot clear: keep converting; enable clear: no conversion at all
// - One-shot set with enable: run the chosen sequence once, then stop
// - Mode 00: convert the selected conversion channel repeatedly forever
// - Mode 01: convert channels zero to seven in order, restarting repeatedly
// - Mode 10: convert the selected conversion channel exactly once
// - Mode 11: convert channels zero to seven once each, then halt
// - Swap bit set exchanges buffer amplifier inputs; clear connects them normally
// - Read-only ready flag at bit 7 sets when a result is available
// - Readback field picks which stored channel result the output registers show
// - Conversion field picks the channel being converted
// - Readback of one channel never disturbs conversion of another, except that a channel select write in halt restarts the one-shot run
// - Manual bit clear: automatic supply choice; set: use supply-select bit
// - Supply-select zero means output rail, one means input rail
// - Results span two registers: upper holds 13:6 or 7:0, lower the rest
`timescale 1ns/100ps
`default_nettype none
`include "asc_consts.svh"

module asc_scan_control #(
  parameter int RES_W = 14,
  parameter logic [2:0] SILICON_REVISION = 3'h5 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic conv_enable_o,
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [RES_W-1:0] conv_data_i,
  output logic input_swap_o,
  output logic input_buffer_disable_o,
  input wire logic ldo_auto_vin_i,
  output logic ldo_use_vin_o
);

  // ==========================================================
  // Parameter check
  if (RES_W != 14 && RES_W != 8) begin : g_res_w_check
    $error("RES_W must be 8 or 14");
  end

  // ==========================================================
  // Register fields
  logic enable_r;
  logic one_shot_r;
  logic all_channel_scan_r;
  logic input_buffer_disable_r;
  logic input_swap_r;
  logic [2:0] readback_channel_r;
  logic [2:0] conversion_channel_r;
  logic ldo_supply_manual_r;
  logic ldo_supply_source_r;
  logic [5:0] ldo_rfu_r;
  logic data_ready_r;
  logic [RES_W-1:0] result_mem_r [0:7];
  logic [2:0] ch_r;
  logic [2:0] ch_nxt;
  asc_pkg::asc_state_type state_r;
  asc_pkg::asc_state_type state_nxt;
  logic [RES_W-1:0] rb_value;
  logic rb_valid;
  logic [2:0] rb_slot;
  logic wr_cfg;
  logic wr_sel;
  logic wr_ldo;
  logic rd_hi;
  logic [7:0] rd_value;
  logic take_result;

  // Maps a readback code onto the slot where that signal's result is stored
  function automatic logic [3:0] rb_map(input logic [2:0] code);
    logic [3:0] slot;
    slot = 4'h0;
    unique case (code)
      3'h0: slot = 4'h3;
      3'h1: slot = 4'h2;
      3'h2: slot = 4'h1;
      3'h3: slot = 4'h0;
      3'h4: slot = 4'h8;
      3'h5: slot = 4'h5;
      3'h6: slot = 4'h6;
      3'h7: slot = 4'h7;
    endcase
    return slot;
  endfunction : rb_map

  // Decodes a register access at one offset
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction : hit

  assign wr_cfg = hit(reg_wr_i, reg_addr_i, `ASC_OFS_CONV_CFG);
  assign wr_sel = hit(reg_wr_i, reg_addr_i, `ASC_OFS_CHAN_SEL);
  assign wr_ldo = hit(reg_wr_i, reg_addr_i, `ASC_OFS_LDO_CTRL);
  assign rd_hi = hit(reg_rd_i, reg_addr_i, `ASC_OFS_RESULT_HI);

  // ==========================================================
  // Conversion config register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {enable_r, one_shot_r, all_channel_scan_r, input_buffer_disable_r, input_swap_r} <= `ASC_RST_CONV_CFG;
    end else if (wr_cfg) begin
      enable_r <= reg_wdata_i[`ASC_CFG_ENABLE];
      one_shot_r <= reg_wdata_i[`ASC_CFG_ONE_SHOT];
      all_channel_scan_r <= reg_wdata_i[`ASC_CFG_ALL_SCAN];
      input_buffer_disable_r <= reg_wdata_i[`ASC_CFG_BUF_DIS];
      input_swap_r <= reg_wdata_i[`ASC_CFG_SWAP];
    end
  end

  // ==========================================================
  // Channel select register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {readback_channel_r, conversion_channel_r} <= `ASC_RST_CHAN_SEL;
    end else if (wr_sel) begin
      readback_channel_r <= reg_wdata_i[`ASC_SEL_RB_HI:`ASC_SEL_RB_LO];
      conversion_channel_r <= reg_wdata_i[`ASC_SEL_CV_HI:`ASC_SEL_CV_LO];
    end
  end

  // ==========================================================
  // LDO supply control register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ldo_rfu_r <= `ASC_RST_LDO_RFU;
      {ldo_supply_manual_r, ldo_supply_source_r} <= `ASC_RST_LDO_CTRL;
    end else if (wr_ldo) begin
      ldo_rfu_r <= reg_wdata_i[`ASC_LDO_RFU_HI:`ASC_LDO_RFU_LO];
      ldo_supply_manual_r <= reg_wdata_i[`ASC_LDO_MANUAL];
      ldo_supply_source_r <= reg_wdata_i[`ASC_LDO_SOURCE];
    end
  end

  // Supply choice, one means input rail
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ldo_use_vin_o <= 1'b0;
    end else begin
      ldo_use_vin_o <= ldo_supply_manual_r ? ldo_supply_source_r : ldo_auto_vin_i;
    end
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    ch_nxt = ch_r;
    if (!enable_r) begin
      state_nxt = asc_pkg::ASC_IDLE;
    end else begin
      unique case (state_r)
        asc_pkg::ASC_IDLE: begin
          state_nxt = asc_pkg::ASC_START;
          ch_nxt = all_channel_scan_r ? `ASC_FIRST_CHAN : conversion_channel_r;
        end
        asc_pkg::ASC_START: begin
          state_nxt = asc_pkg::ASC_WAIT;
        end
        asc_pkg::ASC_WAIT: begin
          if (conv_done_i) begin
            if (all_channel_scan_r && ch_r != `ASC_LAST_CHAN) begin
              state_nxt = asc_pkg::ASC_START;
              ch_nxt = ch_r + 3'h1;
            end else if (one_shot_r) begin
              state_nxt = asc_pkg::ASC_HALT;
            end else begin
              state_nxt = asc_pkg::ASC_START;
              ch_nxt = all_channel_scan_r ? `ASC_FIRST_CHAN : conversion_channel_r;
            end
          end
        end
        asc_pkg::ASC_HALT: begin
          if (wr_cfg || wr_sel) begin
            state_nxt = asc_pkg::ASC_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer state and channel
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= asc_pkg::ASC_IDLE;
      ch_r <= `ASC_FIRST_CHAN;
    end else begin
      state_r <= state_nxt;
      ch_r <= ch_nxt;
    end
  end

  // Converter drive
  assign conv_start_o = (state_r == asc_pkg::ASC_START) && enable_r;
  assign take_result = enable_r && (state_r == asc_pkg::ASC_WAIT) && conv_done_i;
  assign conv_enable_o = enable_r;
  assign conv_chan_o = ch_r;
  assign input_swap_o = input_swap_r;
  assign input_buffer_disable_o = input_buffer_disable_r;

  // ==========================================================
  // Result store, one slot per conversion channel
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        result_mem_r[i] <= '0;
      end
    end else if (take_result) begin
      result_mem_r[ch_r] <= conv_data_i;
    end
  end

  // Ready flag, a new result wins over the clearing read
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_ready_r <= 1'b0;
    end else if (take_result) begin
      data_ready_r <= 1'b1;
    end else if (rd_hi) begin
      data_ready_r <= 1'b0;
    end
  end

  // ==========================================================
  // Readback selection
  always_comb begin
    logic [3:0] slot;
    slot = rb_map(readback_channel_r);
    rb_valid = !slot[3];
    rb_slot = slot[2:0];
    rb_value = rb_valid ? result_mem_r[rb_slot] : '0;
  end

  // Read multiplexer
  always_comb begin
    rd_value = 8'h00;
    unique case (reg_addr_i)
      `ASC_OFS_RESULT_HI: rd_value = rb_value[RES_W-1 -: 8];
      `ASC_OFS_RESULT_LO: rd_value = (RES_W == 14) ? {2'h0, rb_value[5:0]} : 8'h00;
      `ASC_OFS_CONV_CFG: rd_value = {enable_r, one_shot_r, all_channel_scan_r,
                                     input_buffer_disable_r, input_swap_r, SILICON_REVISION};
      `ASC_OFS_CHAN_SEL: rd_value = {data_ready_r, 1'b0, readback_channel_r, conversion_channel_r};
      `ASC_OFS_LDO_CTRL: rd_value = {ldo_rfu_r, ldo_supply_manual_r, ldo_supply_source_r};
      default: rd_value = 8'h00;
    endcase
  end

  // Read data, registered on the read strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_value;
    end
  end

endmodule : asc_scan_control
`default_nettype wire

// >>> tb/asc_scan_control_sva.sv
// Port checker of the scan control block
// Bound onto asc_scan_control, one clock domain
`timescale 1ns/100ps
`default_nettype none
module asc_scan_control_sva (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic conv_enable_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic input_swap_o,
  input wire logic ldo_auto_vin_i,
  input wire logic ldo_use_vin_o
);
  logic os_r, sc_r, man_r, src_r, dn;
  logic [2:0] cv_r;
  assign dn = conv_done_i && conv_enable_o && !reg_wr_i;
  // ====
  // Shadow copies of written fields
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {os_r, sc_r, cv_r, man_r, src_r} <= 7'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h09) {os_r, sc_r} <= reg_wdata_i[6:5];
      if (reg_addr_i == 8'h0a) cv_r <= reg_wdata_i[2:0];
      if (reg_addr_i == 8'h0b) {man_r, src_r} <= reg_wdata_i[1:0];
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_quiet;
    (!conv_start_o) [*8];
  endsequence
  sequence s_next;
    conv_start_o && conv_chan_o == $past(conv_chan_o) + 3'h1;
  endsequence
  property p_off; !conv_enable_o |-> !conv_start_o; endproperty
  a_off: assert property (p_off) else $error("start while off");
  property p_loop; dn && !os_r |=> conv_start_o; endproperty
  a_loop: assert property (p_loop) else $error("loop stopped");
  property p_once; dn && os_r && !sc_r |=> s_quiet; endproperty
  a_once: assert property (p_once) else $error("single repeated");
  property p_scan; dn && sc_r && !(os_r && conv_chan_o == 3'h7) |=> s_next; endproperty
  a_scan: assert property (p_scan) else $error("scan order");
  property p_stop; dn && sc_r && os_r && conv_chan_o == 3'h7 |=> s_quiet; endproperty
  a_stop: assert property (p_stop) else $error("pass repeated");
  property p_pick; conv_start_o && !sc_r |-> conv_chan_o == cv_r; endproperty
  a_pick: assert property (p_pick) else $error("wrong channel");
  property p_swap; reg_wr_i && reg_addr_i == 8'h09 |=> input_swap_o == $past(reg_wdata_i[3]); endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_ldo; ldo_use_vin_o == ($past(man_r) ? $past(src_r) : $past(ldo_auto_vin_i)); endproperty
  a_ldo: assert property (p_ldo) else $error("supply wrong");
endmodule : asc_scan_control_sva
bind asc_scan_control asc_scan_control_sva asc_scan_control_sva_i (.*);
`default_nettype wire

// >>> tb/asc_conv_model.sv
// Converter model, done after a channel-dependent wait
// Assumes start pulses from the scan control block
`timescale 1ns/100ps
`default_nettype none
module asc_conv_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic conv_enable_i,
  input wire logic conv_start_i,
  input wire logic [2:0] conv_chan_i,
  output logic conv_done_o,
  output logic [13:0] conv_data_o
);
  logic [4:0] cnt_r;
  logic [13:0] res;
  // ====
  // Wait grows with channel, power off discards
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cnt_r <= 5'h00;
    else if (!conv_enable_i) cnt_r <= 5'h00;
    else if (conv_start_i) cnt_r <= {1'b0, conv_chan_i, 1'b0} + 5'h02;
    else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
  end
  assign res = {conv_chan_i, 11'h4b1};
  assign conv_done_o = (cnt_r == 5'h01);
  assign conv_data_o = conv_done_o ? res : ~res;
endmodule : asc_conv_model
`default_nettype wire

// >>> tb/adc_scan_control_bench.sv
// Self-checking bench of the scan control block
// Assumes the converter model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module adc_scan_control_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ldo_auto_vin_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o, v, mask;
  logic conv_enable_o, conv_start_o, conv_done_i;
  logic input_swap_o, input_buffer_disable_o, ldo_use_vin_o;
  logic [2:0] conv_chan_o;
  logic [13:0] conv_data_i, e;
  int failures = 0;
  int tests_run = 0;
  int n_st = 0;
  int cyc = 0;
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h80, 8'h00};
  // ====
  // Rows: config, channel, capped starts, channel mask
  logic [7:0] rows [5][4] = '{'{8'h80, 8'h05, 8'h09, 8'h20}, '{8'ha0, 8'h02, 8'h09, 8'hff},
    '{8'hc0, 8'h06, 8'h01, 8'h40}, '{8'he0, 8'h00, 8'h08, 8'hff}, '{8'h00, 8'h03, 8'h00, 8'h00}};
  asc_scan_control asc_scan_control_i (.*);
  asc_conv_model asc_conv_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_enable_i(conv_enable_o),
    .conv_start_i(conv_start_o), .conv_chan_i(conv_chan_o), .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) begin
      n_st++;
      mask[conv_chan_o] = 1'b1;
    end
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic defaults();
    for (int i = 0; i < 6; i++) begin
      rd(8'h07 + 8'(i), v);
      chk(v, rv[i]);
    end
  endtask : defaults
  task automatic tally_and_finish();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    defaults();
    for (int i = 0; i < 5; i++) begin
      wr(8'h09, 8'h00);
      wr(8'h0a, rows[i][1]);
      wr(8'h09, rows[i][0]);
      @(negedge clk_i);
      n_st = 0;
      mask = 8'h00;
      repeat (150) @(posedge clk_i);
      @(negedge clk_i);
      chk((n_st > 9) ? 8'h09 : n_st[7:0], rows[i][2]);
      chk(mask, rows[i][3]);
    end
    wr(8'h0a, 8'h04);
    wr(8'h09, 8'h80);
    @(negedge clk_i);
    chk({7'h00, conv_enable_o}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      e = (c == 4) ? 14'h0000 : {(c > 4) ? c[2:0] : 3'h3 - c[2:0], 11'h4b1};
      wr(8'h0a, {2'h0, c[2:0], 3'h4});
      rd(8'h07, v);
      chk(v, e[13:6]);
      rd(8'h08, v);
      chk(v, {2'h0, e[5:0]});
    end
    wr(8'h09, 8'h00);
    rd(8'h07, v);
    rd(8'h0a, v);
    chk(v, 8'h3c);
    wr(8'h09, 8'hc0);
    repeat (20) @(posedge clk_i);
    rd(8'h0a, v);
    chk(v, 8'hbc);
    // Offset cancelling: one reading per swap setting, averaged
    e = 14'h0000;
    for (int s = 0; s < 2; s++) begin
      wr(8'h09, 8'h00);
      wr(8'h0a, 8'h2d);
      wr(8'h09, {4'hc, s[0], 3'h0});
      repeat (20) @(posedge clk_i);
      rd(8'h07, v);
      e = e + {6'h00, v};
    end
    chk(e[8:1], 8'hb2);
    wr(8'h09, 8'h0f);
    @(negedge clk_i);
    chk({5'h00, conv_enable_o, input_swap_o, input_buffer_disable_o}, 8'h02);
    rd(8'h09, v);
    chk(v, 8'h0d);
    wr(8'h09, 8'h00);
    @(negedge clk_i);
    chk({5'h00, conv_enable_o, input_swap_o, input_buffer_disable_o}, 8'h00);
    @(posedge clk_i);
    ldo_auto_vin_i <= 1'b1;
    wr(8'h0b, 8'h00);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ldo_use_vin_o}, 8'h01);
    wr(8'h0b, 8'h02);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ldo_use_vin_o}, 8'h00);
    @(posedge clk_i);
    ldo_auto_vin_i <= 1'b0;
    wr(8'h0b, 8'h03);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ldo_use_vin_o}, 8'h01);
    wr(8'h0b, 8'h01);
    repeat (2) @(negedge clk_i);
    chk({7'h00, ldo_use_vin_o}, 8'h00);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    defaults();
    tally_and_finish();
  end
endmodule : adc_scan_control_bench
`default_nettype wire
